// *** design/timer_consts.svh ***
// offsets, fields, reset values and divider counts of the dual timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define TIMER_CONTROL_ADDR 8'h88
`define TIMER_MODE_ADDR 8'h89
`define TIMER0_COUNT_LOW_ADDR 8'h8A
`define TIMER1_COUNT_LOW_ADDR 8'h8B
`define TIMER0_COUNT_HIGH_ADDR 8'h8C
`define TIMER1_COUNT_HIGH_ADDR 8'h8D
`define TIMER_CLOCK_SELECT_ADDR 8'h8E

`define REG_RESET 8'h00
`define UNMAPPED_READ 8'h00

// timer_control fields
`define CTL_OVF1_BIT 7
`define CTL_RUN1_BIT 6
`define CTL_OVF0_BIT 5
`define CTL_RUN0_BIT 4
`define CTL_IRQ1_FLAG_BIT 3
`define CTL_IRQ1_EDGE_BIT 2
`define CTL_IRQ0_FLAG_BIT 1
`define CTL_IRQ0_EDGE_BIT 0

// timer_mode fields
`define MOD_GT1_BIT 7
`define MOD_CNT1_BIT 6
`define MOD_MODE1_HI 5
`define MOD_MODE1_LO 4
`define MOD_GT0_BIT 3
`define MOD_CNT0_BIT 2
`define MOD_MODE0_HI 1
`define MOD_MODE0_LO 0

// timer_clock_select fields
`define CKS_FAST1_BIT 4
`define CKS_FAST0_BIT 3
`define CKS_PRESCALE_HI 1
`define CKS_PRESCALE_LO 0
`define CKS_WRITE_MASK 8'h1B

// prescaler divisors
`define PRESCALE_DIV12 6'h0C
`define PRESCALE_DIV4 6'h04
`define PRESCALE_DIV48 6'h30
`define PRESCALE_EXT_DIV8 6'h08

// synchronised pin indices
`define PIN_IRQ0 0
`define PIN_IRQ1 1
`define PIN_EVENT0 2
`define PIN_EVENT1 3
`define PIN_EXT_OSC 4
`define PIN_COUNT 5

`endif

// *** design/timer_pkg.sv ***
// types shared by the dual timer modules
package timer_pkg;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_8BIT_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } timer_mode_t;

    typedef enum logic [1:0] {
        PRESCALE_SYS_DIV12 = 2'h0,
        PRESCALE_SYS_DIV4 = 2'h1,
        PRESCALE_SYS_DIV48 = 2'h2,
        PRESCALE_EXT_DIV8 = 2'h3
    } prescale_sel_t;

endpackage : timer_pkg

// *** design/pin_sync_if.sv ***
// synchronised pin levels and edges passed from the pin synchroniser to the timers
`timescale 1ns/1ps
`include "timer_consts.svh"

interface pin_sync_if;
    logic [`PIN_COUNT-1:0] level;
    logic [`PIN_COUNT-1:0] fall;
    logic [`PIN_COUNT-1:0] rise;

    modport src (output level, output fall, output rise);
    modport dst (input level, input fall, input rise);
endinterface : pin_sync_if

// *** design/pin_sync.sv ***
// two-flop synchronisers with edge detection for the timer pins
`timescale 1ns/1ps
`include "timer_consts.svh"

module pin_sync (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_sync_b_in,
    // raw pins
    input wire logic [`PIN_COUNT-1:0] pins_in,
    // synchronised view
    pin_sync_if.src sync
);
    logic [`PIN_COUNT-1:0] meta_q;
    logic [`PIN_COUNT-1:0] stable_q;
    logic [`PIN_COUNT-1:0] last_q;

    genvar i;
    generate
        for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
            // idle high so a released reset never looks like a falling edge
            always_ff @(posedge core_clk_in or negedge rst_sync_b_in) begin
                if (!rst_sync_b_in) begin
                    meta_q[i] <= 1'b1;
                    stable_q[i] <= 1'b1;
                    last_q[i] <= 1'b1;
                end else begin
                    meta_q[i] <= pins_in[i];
                    stable_q[i] <= meta_q[i];
                    last_q[i] <= stable_q[i];
                end
            end
            assign sync.level[i] = stable_q[i];
            assign sync.fall[i] = last_q[i] & ~stable_q[i];
            assign sync.rise[i] = ~last_q[i] & stable_q[i];
        end
    endgenerate

endmodule : pin_sync

// *** design/dual_timer.sv ***
// two classic counter/timers with control, mode, clock-select and count registers
//
// Summary of operation
// - mode 1 counts full sixteen-bit byte pair
// - mode 2 wraps low byte, reloads from high
// - set overflow flag with enable raises request
// - split mode: low byte uses timer 0 controls
// - split high byte times, runs on timer1 run
// - split: timer 1 no events, no flag
// - split: timer 1 runs unless mode 3
// - overflow flags set by hardware, cleared otherwise
// - run bits start and stop timers
// - external flags set by edge or level
// - type bit picks level or falling edge
// - gate bit adds irq pin high condition
// - counter select picks clock or event pin
// - two-bit mode field decodes four modes
// - clock select picks system or prescaled clock
// - prescale field picks 12, 4, 48, ext/8
// - unused clock-select bits read zero
// - mode 0 is 13-bit, wraps at 0x1FFF
// - run bit never clears the counts
`timescale 1ns/1ps
`include "timer_consts.svh"

module dual_timer (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // special function register access
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // interrupt controller side
    input wire logic timer0_irq_en_in,
    input wire logic timer1_irq_en_in,
    input wire logic timer0_vector_ack_in,
    input wire logic timer1_vector_ack_in,
    input wire logic ext_irq0_vector_ack_in,
    input wire logic ext_irq1_vector_ack_in,
    output logic timer0_irq_out,
    output logic timer1_irq_out,
    output logic ext_irq0_req_out,
    output logic ext_irq1_req_out,
    // overflow pulse for baud and converter triggering
    output logic timer1_ovf_pulse_out,
    // pins
    input wire logic ext_irq0_pin_b_in,
    input wire logic ext_irq1_pin_b_in,
    input wire logic timer0_event_pin_in,
    input wire logic timer1_event_pin_in,
    input wire logic ext_osc_clk_in
);
    logic rst_meta_q;
    logic rst_sync_b_q;
    logic [7:0] cr_q;
    logic [7:0] cr_d;
    logic [7:0] md_q;
    logic [7:0] cs_q;
    logic [7:0] l0_q;
    logic [7:0] l0_d;
    logic [7:0] h0_q;
    logic [7:0] h0_d;
    logic [7:0] l1_q;
    logic [7:0] l1_d;
    logic [7:0] h1_q;
    logic [7:0] h1_d;
    logic [5:0] presc_cnt_q;
    logic [5:0] presc_cnt_d;
    logic [7:0] rdata_d;

    pin_sync_if pins ();

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_b_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_b_q <= rst_meta_q;
        end
    end

    pin_sync u_pin_sync (
        .core_clk_in(core_clk_in),
        .rst_sync_b_in(rst_sync_b_q),
        .pins_in({ext_osc_clk_in, timer1_event_pin_in, timer0_event_pin_in,
                  ext_irq1_pin_b_in, ext_irq0_pin_b_in}),
        .sync(pins)
    );

    // returns {overflow, high, low} after one increment
    function automatic logic [16:0] count_step(input timer_pkg::timer_mode_t mode,
                                               input logic [7:0] lo,
                                               input logic [7:0] hi);
        logic [5:0] l5;
        logic [8:0] l9;
        logic [8:0] h9;
        l5 = {1'b0, lo[4:0]} + 6'h01;
        l9 = {1'b0, lo} + 9'h001;
        h9 = 9'h000;
        count_step = 17'h00000;
        unique case (mode)
            timer_pkg::MODE_13BIT: begin
                // upper low-byte bits are left alone and read back their held value
                h9 = {1'b0, hi} + {8'h00, l5[5]};
                count_step = {h9[8], h9[7:0], lo[7:5], l5[4:0]};
            end
            timer_pkg::MODE_16BIT: begin
                h9 = {1'b0, hi} + {8'h00, l9[8]};
                count_step = {h9[8], h9[7:0], l9[7:0]};
            end
            timer_pkg::MODE_8BIT_RELOAD: begin
                count_step = {l9[8], hi, l9[8] ? hi : l9[7:0]};
            end
            timer_pkg::MODE_SPLIT: begin
                count_step = {l9[8], hi, l9[7:0]};
            end
        endcase
    endfunction : count_step

    // register decode
    wire wr_cr = sfr_wr_in && (sfr_addr_in == `TIMER_CONTROL_ADDR);
    wire wr_md = sfr_wr_in && (sfr_addr_in == `TIMER_MODE_ADDR);
    wire wr_l0 = sfr_wr_in && (sfr_addr_in == `TIMER0_COUNT_LOW_ADDR);
    wire wr_l1 = sfr_wr_in && (sfr_addr_in == `TIMER1_COUNT_LOW_ADDR);
    wire wr_h0 = sfr_wr_in && (sfr_addr_in == `TIMER0_COUNT_HIGH_ADDR);
    wire wr_h1 = sfr_wr_in && (sfr_addr_in == `TIMER1_COUNT_HIGH_ADDR);
    wire wr_cs = sfr_wr_in && (sfr_addr_in == `TIMER_CLOCK_SELECT_ADDR);

    // field views
    wire r1 = cr_q[`CTL_RUN1_BIT];
    wire r0 = cr_q[`CTL_RUN0_BIT];
    wire e1 = cr_q[`CTL_IRQ1_EDGE_BIT];
    wire e0 = cr_q[`CTL_IRQ0_EDGE_BIT];
    wire g1 = md_q[`MOD_GT1_BIT];
    wire g0 = md_q[`MOD_GT0_BIT];
    wire cnt_sel1 = md_q[`MOD_CNT1_BIT];
    wire cnt_sel0 = md_q[`MOD_CNT0_BIT];
    wire timer_pkg::timer_mode_t mode1 =
        timer_pkg::timer_mode_t'(md_q[`MOD_MODE1_HI:`MOD_MODE1_LO]);
    wire timer_pkg::timer_mode_t mode0 =
        timer_pkg::timer_mode_t'(md_q[`MOD_MODE0_HI:`MOD_MODE0_LO]);
    wire fast1 = cs_q[`CKS_FAST1_BIT];
    wire fast0 = cs_q[`CKS_FAST0_BIT];
    wire timer_pkg::prescale_sel_t presc_sel =
        timer_pkg::prescale_sel_t'(cs_q[`CKS_PRESCALE_HI:`CKS_PRESCALE_LO]);

    // the external clock is sampled, so it must stay below a quarter of the core
    logic [5:0] presc_div;
    always_comb begin
        unique case (presc_sel)
            timer_pkg::PRESCALE_SYS_DIV12: presc_div = `PRESCALE_DIV12;
            timer_pkg::PRESCALE_SYS_DIV4: presc_div = `PRESCALE_DIV4;
            timer_pkg::PRESCALE_SYS_DIV48: presc_div = `PRESCALE_DIV48;
            timer_pkg::PRESCALE_EXT_DIV8: presc_div = `PRESCALE_EXT_DIV8;
        endcase
    end
    wire presc_src = (presc_sel == timer_pkg::PRESCALE_EXT_DIV8) ?
                     pins.rise[`PIN_EXT_OSC] : 1'b1;
    wire presc_last = (presc_cnt_q >= presc_div - 6'h01);
    wire presc_tick = presc_src && presc_last;
    assign presc_cnt_d = !presc_src ? presc_cnt_q :
                         (presc_last ? 6'h00 : presc_cnt_q + 6'h01);

    // timer clock after clock select, then counter select
    wire c0_clk_tick = fast0 ? 1'b1 : presc_tick;
    wire c1_clk_tick = fast1 ? 1'b1 : presc_tick;
    wire c0_src_tick = cnt_sel0 ? pins.fall[`PIN_EVENT0] : c0_clk_tick;
    wire c1_src_tick = cnt_sel1 ? pins.fall[`PIN_EVENT1] : c1_clk_tick;

    // gating: run bit, and irq pin high when the gate is set
    wire c0_enable = r0 && (!g0 || pins.level[`PIN_IRQ0]);
    wire c1_enable = r1 && (!g1 || pins.level[`PIN_IRQ1]);

    wire c0_split = (mode0 == timer_pkg::MODE_SPLIT);
    wire c1_active = (mode1 != timer_pkg::MODE_SPLIT);

    // timer 0 low byte (whole timer outside split mode)
    wire c0_inc = c0_enable && c0_src_tick;
    wire [16:0] c0_step = count_step(mode0, l0_q, h0_q);
    wire c0_ovf = c0_inc && c0_step[16];

    // split high byte: timer-only, run by timer 1's run bit
    wire h0_inc = c0_split && r1 && c0_clk_tick;
    wire h0_ovf = h0_inc && (h0_q == 8'hFF);

    // timer 1: in split mode it ignores its run bit, gate and event pin
    wire c1_inc = c0_split ? (c1_active && c1_clk_tick)
                           : (c1_active && c1_enable && c1_src_tick);
    wire [16:0] c1_step = count_step(mode1, l1_q, h1_q);
    wire c1_ovf = c1_inc && c1_step[16];

    // software writes win over a same-cycle count; run bit never touches counts
    assign l0_d = wr_l0 ? sfr_wdata_in : (c0_inc ? c0_step[7:0] : l0_q);
    assign h0_d = wr_h0 ? sfr_wdata_in :
                  c0_split ? (h0_inc ? h0_q + 8'h01 : h0_q) :
                  (c0_inc ? c0_step[15:8] : h0_q);
    assign l1_d = wr_l1 ? sfr_wdata_in : (c1_inc ? c1_step[7:0] : l1_q);
    assign h1_d = wr_h1 ? sfr_wdata_in : (c1_inc ? c1_step[15:8] : h1_q);

    // flag sources; timer 1 flag comes from the split high byte in split mode
    wire f1_set = c0_split ? h0_ovf : c1_ovf;
    wire f0_set = c0_ovf;
    wire f1_keep = wr_cr ? sfr_wdata_in[`CTL_OVF1_BIT]
                         : (cr_q[`CTL_OVF1_BIT] && !timer1_vector_ack_in);
    wire f0_keep = wr_cr ? sfr_wdata_in[`CTL_OVF0_BIT]
                         : (cr_q[`CTL_OVF0_BIT] && !timer0_vector_ack_in);

    // external flags: edge mode latches, level mode mirrors the inverted pin
    wire x1_keep = wr_cr ? sfr_wdata_in[`CTL_IRQ1_FLAG_BIT]
                         : (cr_q[`CTL_IRQ1_FLAG_BIT] && !ext_irq1_vector_ack_in);
    wire x0_keep = wr_cr ? sfr_wdata_in[`CTL_IRQ0_FLAG_BIT]
                         : (cr_q[`CTL_IRQ0_FLAG_BIT] && !ext_irq0_vector_ack_in);
    wire x1_next = e1 ? (pins.fall[`PIN_IRQ1] || x1_keep)
                      : !pins.level[`PIN_IRQ1];
    wire x0_next = e0 ? (pins.fall[`PIN_IRQ0] || x0_keep)
                      : !pins.level[`PIN_IRQ0];

    // a hardware set wins over a same-cycle clear
    always_comb begin
        cr_d = wr_cr ? sfr_wdata_in : cr_q;
        cr_d[`CTL_OVF1_BIT] = f1_set || f1_keep;
        cr_d[`CTL_OVF0_BIT] = f0_set || f0_keep;
        cr_d[`CTL_IRQ1_FLAG_BIT] = x1_next;
        cr_d[`CTL_IRQ0_FLAG_BIT] = x0_next;
    end

    // read mux
    always_comb begin
        unique case (sfr_addr_in)
            `TIMER_CONTROL_ADDR: rdata_d = cr_q;
            `TIMER_MODE_ADDR: rdata_d = md_q;
            `TIMER0_COUNT_LOW_ADDR: rdata_d = l0_q;
            `TIMER1_COUNT_LOW_ADDR: rdata_d = l1_q;
            `TIMER0_COUNT_HIGH_ADDR: rdata_d = h0_q;
            `TIMER1_COUNT_HIGH_ADDR: rdata_d = h1_q;
            `TIMER_CLOCK_SELECT_ADDR: rdata_d = cs_q & `CKS_WRITE_MASK;
            default: rdata_d = `UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            cr_q <= `REG_RESET;
            md_q <= `REG_RESET;
            cs_q <= `REG_RESET;
            presc_cnt_q <= 6'h00;
        end else begin
            cr_q <= cr_d;
            md_q <= wr_md ? sfr_wdata_in : md_q;
            cs_q <= wr_cs ? (sfr_wdata_in & `CKS_WRITE_MASK) : cs_q;
            presc_cnt_q <= presc_cnt_d;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            l0_q <= `REG_RESET;
            h0_q <= `REG_RESET;
            l1_q <= `REG_RESET;
            h1_q <= `REG_RESET;
        end else begin
            l0_q <= l0_d;
            h0_q <= h0_d;
            l1_q <= l1_d;
            h1_q <= h1_d;
        end
    end

    // outputs, all registered
    always_ff @(posedge core_clk_in or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            sfr_rdata_out <= `UNMAPPED_READ;
            timer0_irq_out <= 1'b0;
            timer1_irq_out <= 1'b0;
            ext_irq0_req_out <= 1'b0;
            ext_irq1_req_out <= 1'b0;
            timer1_ovf_pulse_out <= 1'b0;
        end else begin
            sfr_rdata_out <= rdata_d;
            timer0_irq_out <= cr_q[`CTL_OVF0_BIT] && timer0_irq_en_in;
            timer1_irq_out <= cr_q[`CTL_OVF1_BIT] && timer1_irq_en_in;
            ext_irq0_req_out <= cr_q[`CTL_IRQ0_FLAG_BIT];
            ext_irq1_req_out <= cr_q[`CTL_IRQ1_FLAG_BIT];
            // still pulses in split mode for baud and converter use
            timer1_ovf_pulse_out <= c1_ovf;
        end
    end

endmodule : dual_timer

// *** verif/dual_timer_assertions.sv ***
// port-level checks of the dual timer
`timescale 1ns/1ps
`include "timer_consts.svh"

module dual_timer_checker (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // register access
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    // interrupt side
    input wire logic timer0_irq_en_in,
    input wire logic timer0_vector_ack_in,
    input wire logic timer0_irq_out,
    input wire logic timer1_irq_out,
    input wire logic ext_irq0_req_out,
    input wire logic ext_irq1_req_out,
    input wire logic timer1_ovf_pulse_out,
    // pins
    input wire logic ext_irq0_pin_b_in,
    input wire logic ext_irq1_pin_b_in
);
    logic ctl_wr;
    logic [7:0] mode_q;
    logic [2:0] ctl_q;
    assign ctl_wr = sfr_wr_in && (sfr_addr_in == `TIMER_CONTROL_ADDR);
    // shadows of bits that only software changes
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_q <= 8'h00;
            ctl_q <= 3'h0;
        end else if (ctl_wr) begin
            ctl_q <= {sfr_wdata_in[4], sfr_wdata_in[2], sfr_wdata_in[0]};
        end else if (sfr_wr_in && sfr_addr_in == `TIMER_MODE_ADDR) begin
            mode_q <= sfr_wdata_in;
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_irq0_en;
        timer0_irq_out |-> $past(timer0_irq_en_in);
    endproperty
    a_irq0_en: assert property (p_irq0_en) else $error("request without enable");
    property p_run0;
        $rose(timer0_irq_out) && $past(timer0_irq_en_in, 2) |-> $past(ctl_q[2], 2) || $past(ctl_wr, 2);
    endproperty
    a_run0: assert property (p_run0) else $error("overflow while stopped");
    property p_ack0;
        timer0_vector_ack_in && !ctl_q[2] && !ctl_wr ##1 !ctl_wr |=> !timer0_irq_out;
    endproperty
    a_ack0: assert property (p_ack0) else $error("flag kept after vectoring");
    property p_cks_rd;
        $past(sfr_addr_in) == `TIMER_CLOCK_SELECT_ADDR |-> (sfr_rdata_out & 8'hE4) == 8'h00;
    endproperty
    a_cks_rd: assert property (p_cks_rd) else $error("unused clock bits set");
    property p_mode_rb;
        sfr_wr_in && sfr_addr_in == `TIMER_MODE_ADDR ##1 sfr_addr_in == `TIMER_MODE_ADDR
            |=> sfr_rdata_out == $past(sfr_wdata_in, 2);
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
    property p_t1_off;
        (mode_q[5:4] == 2'h3)[*3] |-> !timer1_ovf_pulse_out;
    endproperty
    a_t1_off: assert property (p_t1_off) else $error("timer 1 ran in mode 3");
    property p_lvl0;
        (!ctl_q[0] && !ext_irq0_pin_b_in)[*8] ##1 !ext_irq0_pin_b_in |-> ext_irq0_req_out;
    endproperty
    a_lvl0: assert property (p_lvl0) else $error("level request missing");
    property p_lvl1;
        (!ctl_q[1] && ext_irq1_pin_b_in)[*8] ##1 ext_irq1_pin_b_in |-> !ext_irq1_req_out;
    endproperty
    a_lvl1: assert property (p_lvl1) else $error("level request with pin high");
    c_irq0: cover property ($rose(timer0_irq_out));
    c_irq1: cover property ($rose(timer1_irq_out));
    c_pulse: cover property ($rose(timer1_ovf_pulse_out));
endmodule : dual_timer_checker

bind dual_timer dual_timer_checker dual_timer_checker_inst (
    .core_clk_in,
    .rst_b_in,
    .sfr_addr_in,
    .sfr_wr_in,
    .sfr_wdata_in,
    .sfr_rdata_out,
    .timer0_irq_en_in,
    .timer0_vector_ack_in,
    .timer0_irq_out,
    .timer1_irq_out,
    .ext_irq0_req_out,
    .ext_irq1_req_out,
    .timer1_ovf_pulse_out,
    .ext_irq0_pin_b_in,
    .ext_irq1_pin_b_in
);

// *** verif/pin_model.sv ***
// far-side pins: interrupt levels, event pulses and an external oscillator
`timescale 1ns/1ps

module pin_model (
    // clock
    input wire logic core_clk_in,
    // pins toward the timer
    output logic ext_irq0_pin_b_out,
    output logic ext_irq1_pin_b_out,
    output logic [1:0] event_pin_out,
    output logic ext_osc_clk_out
);
    // oscillator at an eighth of the core rate, under the quarter-rate limit
    initial begin
        ext_irq0_pin_b_out = 1'b1;
        ext_irq1_pin_b_out = 1'b1;
        event_pin_out = 2'h3;
        ext_osc_clk_out = 1'b0;
        forever begin
            repeat (4) @(posedge core_clk_in);
            ext_osc_clk_out <= !ext_osc_clk_out;
        end
    end
    // three cycles per level so the sampler cannot miss one
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge core_clk_in) event_pin_out[idx] <= 1'b0;
            repeat (3) @(posedge core_clk_in);
            event_pin_out[idx] <= 1'b1;
            repeat (3) @(posedge core_clk_in);
        end
    endtask : pulse
    task automatic set_irq(input int idx, input logic lvl);
        @(posedge core_clk_in);
        if (idx == 0) begin
            ext_irq0_pin_b_out <= lvl;
        end else begin
            ext_irq1_pin_b_out <= lvl;
        end
    endtask : set_irq
endmodule : pin_model

// *** verif/tb.sv ***
// self-checking bench of the dual timer with a reference count model
`timescale 1ns/1ps
`include "timer_consts.svh"

module tb;
    logic core_clk_in, rst_b_in, wr, pls, pin0_b, pin1_b, osc;
    logic [7:0] addr, wdata, rdata, v, w;
    logic [1:0] en, irq, xreq, ev;
    logic [3:0] ack;
    logic [31:0] seed;
    int n, bad_count, checks_done;

    dual_timer dual_timer_inst (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .sfr_addr_in(addr),
        .sfr_wr_in(wr),
        .sfr_wdata_in(wdata),
        .sfr_rdata_out(rdata),
        .timer0_irq_en_in(en[0]),
        .timer1_irq_en_in(en[1]),
        .timer0_vector_ack_in(ack[0]),
        .timer1_vector_ack_in(ack[1]),
        .ext_irq0_vector_ack_in(ack[2]),
        .ext_irq1_vector_ack_in(ack[3]),
        .timer0_irq_out(irq[0]),
        .timer1_irq_out(irq[1]),
        .ext_irq0_req_out(xreq[0]),
        .ext_irq1_req_out(xreq[1]),
        .timer1_ovf_pulse_out(pls),
        .ext_irq0_pin_b_in(pin0_b),
        .ext_irq1_pin_b_in(pin1_b),
        .timer0_event_pin_in(ev[0]),
        .timer1_event_pin_in(ev[1]),
        .ext_osc_clk_in(osc)
    );
    pin_model pin_model_inst (
        .core_clk_in(core_clk_in),
        .ext_irq0_pin_b_out(pin0_b),
        .ext_irq1_pin_b_out(pin1_b),
        .event_pin_out(ev),
        .ext_osc_clk_out(osc)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = !core_clk_in;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wr <= 1'b1;
        wdata <= d;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        addr <= a;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        d = rdata;
    endtask : rd_reg
    task automatic vec_ack(input int k);
        @(posedge core_clk_in);
        ack[k] <= 1'b1;
        @(posedge core_clk_in);
        ack[k] <= 1'b0;
    endtask : vec_ack
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // reference count: returns overflow seen, high byte, low byte
    function automatic logic [16:0] adv(input int md, input logic [7:0] lo,
                                        input logic [7:0] hi, input int k);
        logic ov;
        logic [12:0] s;
        ov = 1'b0;
        repeat (k) begin
            if (md == 2) begin
                ov |= (lo == 8'hFF);
                lo = (lo == 8'hFF) ? hi : lo + 8'h01;
            end else if (md == 1) begin
                {hi, lo} = {hi, lo} + 16'h0001;
                ov |= ({hi, lo} == 16'h0000);
            end else begin
                s = {hi, lo[4:0]} + 13'h0001;
                {hi, lo[4:0]} = s;
                ov |= (s == 13'h0000);
            end
        end
        return {ov, hi, lo};
    endfunction : adv
    task automatic count_run(input int t, input int md, input logic [7:0] lo,
                             input logic [7:0] hi, input int k);
        logic [7:0] d;
        logic [7:0] msk;
        logic [16:0] e;
        e = adv(md, lo, hi, k);
        msk = (md == 0) ? 8'h1F : 8'hFF;
        d = (t == 1) ? (8'h40 | 8'(md << 4)) : (8'h04 | 8'(md));
        wr_reg(`TIMER_CONTROL_ADDR, 8'h00);
        wr_reg(`TIMER_MODE_ADDR, d);
        wr_reg(`TIMER0_COUNT_LOW_ADDR + 8'(t), lo);
        wr_reg(`TIMER0_COUNT_HIGH_ADDR + 8'(t), hi);
        wr_reg(`TIMER_CONTROL_ADDR, (t == 1) ? 8'h40 : 8'h10);
        pin_model_inst.pulse(t, k);
        rd_reg(`TIMER_CONTROL_ADDR, d);
        chk("overflow flag", d[5 + 2 * t], e[16]);
        chk("timer request", irq[t], e[16]);
        rd_reg(`TIMER0_COUNT_HIGH_ADDR + 8'(t), d);
        chk("count high", d, e[15:8]);
        rd_reg(`TIMER0_COUNT_LOW_ADDR + 8'(t), d);
        chk("count low", d & msk, e[7:0] & msk);
    endtask : count_run

    initial begin
        repeat (20000) @(posedge core_clk_in);
        bad_count++;
        print_verdict();
    end

    initial begin
        rst_b_in = 1'b0;
        addr = 8'h00;
        wr = 1'b0;
        wdata = 8'h00;
        en = 2'h3;
        ack = 4'h0;
        bad_count = 0;
        checks_done = 0;
        seed = 32'h209ED432;
        repeat (5) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        for (int a = 8'h88; a <= 8'h8F; a++) begin
            rd_reg(8'(a), v);
            chk("reset value", v, 16'h0000);
        end
        wr_reg(`TIMER_CLOCK_SELECT_ADDR, 8'hFF);
        rd_reg(`TIMER_CLOCK_SELECT_ADDR, v);
        chk("clock select", v, 16'h001B);
        repeat (4) begin
            seed = lfsr(seed);
            wr_reg(`TIMER_MODE_ADDR, seed[7:0]);
            rd_reg(`TIMER_MODE_ADDR, v);
            chk("timer mode", v, seed[7:0]);
        end
        seed = lfsr(seed);
        count_run(0, 1, seed[7:0], 8'hFF, 3);
        count_run(1, 2, 8'hFE, 8'hF0, 4);
        count_run(0, 0, 8'h1E, 8'hFF, 2);
        count_run(1, 1, 8'hFF, 8'hFF, 1);
        wr_reg(`TIMER_CONTROL_ADDR, 8'h20);
        repeat (2) @(negedge core_clk_in);
        chk("software flag request", irq[0], 1'b1);
        vec_ack(0);
        rd_reg(`TIMER_CONTROL_ADDR, v);
        chk("flag after vectoring", v[5], 1'b0);
        // gate pin low must hold the count, then counting resumes
        wr_reg(`TIMER_MODE_ADDR, 8'h0D);
        wr_reg(`TIMER0_COUNT_LOW_ADDR, 8'h00);
        pin_model_inst.set_irq(0, 1'b0);
        wr_reg(`TIMER_CONTROL_ADDR, 8'h10);
        pin_model_inst.pulse(0, 2);
        rd_reg(`TIMER0_COUNT_LOW_ADDR, v);
        chk("gated count", v, 16'h0000);
        rd_reg(`TIMER_CONTROL_ADDR, v);
        chk("level flag", v[1], 1'b1);
        chk("level request", xreq[0], 1'b1);
        pin_model_inst.set_irq(0, 1'b1);
        pin_model_inst.pulse(0, 2);
        rd_reg(`TIMER0_COUNT_LOW_ADDR, v);
        chk("resumed count", v, 16'h0002);
        rd_reg(`TIMER_CONTROL_ADDR, v);
        chk("level flag released", v[1], 1'b0);
        wr_reg(`TIMER_CONTROL_ADDR, 8'h01);
        pin_model_inst.set_irq(0, 1'b0);
        repeat (3) @(posedge core_clk_in);
        pin_model_inst.set_irq(0, 1'b1);
        repeat (6) @(negedge core_clk_in);
        rd_reg(`TIMER_CONTROL_ADDR, v);
        chk("edge flag", v[1], 1'b1);
        vec_ack(2);
        rd_reg(`TIMER_CONTROL_ADDR, v);
        chk("edge flag vectored", v[1], 1'b0);
        // split: low byte counts events, high byte times on timer 1 run
        wr_reg(`TIMER_CONTROL_ADDR, 8'h00);
        wr_reg(`TIMER_MODE_ADDR, 8'h37);
        wr_reg(`TIMER_CLOCK_SELECT_ADDR, 8'h08);
        wr_reg(`TIMER0_COUNT_LOW_ADDR, 8'h00);
        wr_reg(`TIMER0_COUNT_HIGH_ADDR, 8'hFE);
        wr_reg(`TIMER_CONTROL_ADDR, 8'h50);
        pin_model_inst.pulse(0, 1);
        rd_reg(`TIMER0_COUNT_LOW_ADDR, v);
        chk("split low count", v, 16'h0001);
        rd_reg(`TIMER_CONTROL_ADDR, v);
        chk("split high overflow", v[7], 1'b1);
        chk("split request", irq[1], 1'b1);
        wr_reg(`TIMER_CONTROL_ADDR, 8'h10);
        wr_reg(`TIMER1_COUNT_LOW_ADDR, 8'hFF);
        wr_reg(`TIMER1_COUNT_HIGH_ADDR, 8'hFF);
        wr_reg(`TIMER_CLOCK_SELECT_ADDR, 8'h18);
        wr_reg(`TIMER_MODE_ADDR, 8'h57);
        for (n = 0; n < 20 && pls !== 1'b1; n++) begin
            @(negedge core_clk_in);
        end
        chk("overflow pulse", 16'(n < 20), 16'h0001);
        if (n == 20) begin
            print_verdict();
        end
        rd_reg(`TIMER_CONTROL_ADDR, v);
        chk("no timer 1 flag", v[7], 1'b0);
        wr_reg(`TIMER_MODE_ADDR, 8'h37);
        rd_reg(`TIMER1_COUNT_LOW_ADDR, v);
        repeat (5) @(negedge core_clk_in);
        rd_reg(`TIMER1_COUNT_LOW_ADDR, w);
        chk("halted timer 1", w, v);
        print_verdict();
    end
endmodule : tb
